// ==== logic/sde_pkg.sv ====
// Constants, register map and states of the check-unit host controller
package sde_pkg;
  // Widths
  localparam int DW = 16;
  localparam int CW = 6;
  localparam int RAW = 8;
  localparam int CNT_W = 8;
  // Own register offsets
  localparam logic [RAW-1:0] REG_CTRL = 8'h00;
  localparam logic [RAW-1:0] REG_ADDR = 8'h04;
  localparam logic [RAW-1:0] REG_WDATA = 8'h08;
  localparam logic [RAW-1:0] REG_BYTESEL = 8'h0c;
  localparam logic [RAW-1:0] REG_STATUS = 8'h10;
  localparam logic [RAW-1:0] REG_RDATA = 8'h14;
  localparam logic [RAW-1:0] REG_SYND = 8'h18;
  // Control bits
  localparam int CTRL_WR_BIT = 0;
  localparam int CTRL_RD_BIT = 1;
  localparam int CTRL_RMW_BIT = 2;
  localparam int CTRL_CLR_BIT = 3;
  // Status bits
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_CLEAN_BIT = 1;
  localparam int ST_CORR_BIT = 2;
  localparam int ST_UNCORR_BIT = 3;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_SETTLE_NS = 50;
  localparam int SETTLE_CYC = (T_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 2;
  localparam logic [CNT_W-1:0] WAIT_SETTLE = CNT_W'(SETTLE_CYC);
  localparam logic [CNT_W-1:0] WAIT_SAMPLE = CNT_W'(SETTLE_CYC + SYNC_STAGES);
  localparam logic [CNT_W-1:0] WAIT_ONE = 8'h01;
  // Mode select codes {hi, lo}
  localparam logic [1:0] MODE_GEN = 2'b00;
  localparam logic [1:0] MODE_FLAG = 2'b10;
  localparam logic [1:0] MODE_LATCH = 2'b11;
  // Sequencer states
  typedef enum logic [3:0] {
    SDE_IDLE = 4'h0,
    SDE_RD_FLAG = 4'h1,
    SDE_LATCH_IN = 4'h2,
    SDE_HOLD = 4'h3,
    SDE_OUT_CORR = 4'h4,
    SDE_WR_GEN = 4'h5,
    SDE_WR_STROBE = 4'h6,
    SDE_DONE = 4'h7
  } sde_state_t;
endpackage

// ==== logic/sde_host.sv ====
// Host controller sequencing a 16-bit check/correct unit and its memory
// Operation
// - Read-flag transparent, latch mode captures words
// - Capture memory word before byte write
// - Output latch holds on rising control
// - High byte enable lets host drive byte
// - Regenerate check word before write back
// - Generate mode drives check bits out
// - Accept read data only with flags high
// - Correctable flag starts correction sequence
// - Both flags low: uncorrectable, raise interrupt
module sde_host #(
  parameter int MAW = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Register port
  input wire logic [sde_pkg::RAW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Unit control pins
  output logic mode_select_hi,
  output logic mode_select_lo,
  output logic low_byte_out_enable_n,
  output logic high_byte_out_enable_n,
  output logic data_out_latch_ctl_n,
  output logic check_port_out_enable_n,
  input wire logic fault_flag_n,
  input wire logic multi_fault_flag_n,
  // Shared data and check lines
  input wire logic [sde_pkg::DW-1:0] data_word_in,
  output logic [sde_pkg::DW-1:0] data_word_out,
  output logic [1:0] data_word_oe_n,
  input wire logic [sde_pkg::CW-1:0] check_bit_in,
  // Memory array strobes
  output logic [MAW-1:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  // Processor interrupt
  output logic uncorr_irq
);
  import sde_pkg::*;

  sde_state_t state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] wait_lim;
  logic wait_done;
  logic rmw_r, rd_op_r;
  logic [MAW-1:0] addr_r;
  logic [DW-1:0] wdata_r, rdata_r;
  logic [1:0] bytesel_r;
  logic [CW-1:0] synd_r;
  logic clean_r, corr_r, uncorr_r, uncorr_set;
  logic [DW-1:0] db_m_r, db_s_r;
  logic [CW-1:0] cb_m_r, cb_s_r;
  logic [1:0] fl_m_r, fl_s_r;
  logic flags_clean, flags_corr, flags_uncorr;
  logic ctrl_wr, start_any, rmw_live;

  // Mode pins per state; generate mode only while writing back
  function automatic logic [1:0] pin_mode(input sde_state_t s);
    case (s)
      SDE_LATCH_IN, SDE_HOLD, SDE_OUT_CORR: pin_mode = MODE_LATCH;
      SDE_WR_GEN, SDE_WR_STROBE: pin_mode = MODE_GEN;
      default: pin_mode = MODE_FLAG;
    endcase
  endfunction

  // Pin inputs pass two flops; the first stage is read by nothing else
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      db_m_r <= '0;
      db_s_r <= '0;
      cb_m_r <= '0;
      cb_s_r <= '0;
      fl_m_r <= 2'h3;
      fl_s_r <= 2'h3;
    end
    else
    begin
      db_m_r <= data_word_in;
      db_s_r <= db_m_r;
      cb_m_r <= check_bit_in;
      cb_s_r <= cb_m_r;
      fl_m_r <= {multi_fault_flag_n, fault_flag_n};
      fl_s_r <= fl_m_r;
    end
  end

  assign flags_clean = (fl_s_r == 2'h3);
  assign flags_corr = (fl_s_r == 2'h2);
  assign flags_uncorr = !fl_s_r[1];
  assign ctrl_wr = reg_wr && (reg_addr == REG_CTRL);
  assign start_any = ctrl_wr && (state_r == SDE_IDLE) &&
                     (reg_wdata[CTRL_WR_BIT] || reg_wdata[CTRL_RD_BIT] ||
                      reg_wdata[CTRL_RMW_BIT]);
  // Write back entered straight from idle is always a plain write; the merge flag may still be stale
  assign rmw_live = rmw_r && (state_r != SDE_IDLE);

  // Wait length per state; sampling states add the synchroniser delay
  always_comb
  begin
    unique case (state_r)
      SDE_RD_FLAG, SDE_OUT_CORR: wait_lim = WAIT_SAMPLE;
      SDE_LATCH_IN, SDE_WR_GEN: wait_lim = WAIT_SETTLE;
      default: wait_lim = WAIT_ONE;
    endcase
  end
  assign wait_done = (cnt_r == wait_lim - WAIT_ONE);

  // Sequencer
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      SDE_IDLE:
        if (start_any)
          state_nxt = (reg_wdata[CTRL_RD_BIT] || reg_wdata[CTRL_RMW_BIT]) ?
                      SDE_RD_FLAG : SDE_WR_GEN;
      SDE_RD_FLAG:
        if (wait_done)
        begin
          if (flags_uncorr)
            state_nxt = SDE_DONE;
          else if (rmw_r || flags_corr)
            state_nxt = SDE_LATCH_IN;
          else
            state_nxt = SDE_DONE;
        end
      SDE_LATCH_IN:
        if (wait_done)
          state_nxt = SDE_HOLD;
      SDE_HOLD:
        state_nxt = rmw_r ? SDE_WR_GEN : SDE_OUT_CORR;
      SDE_OUT_CORR:
        if (wait_done)
          state_nxt = SDE_DONE;
      SDE_WR_GEN:
        if (wait_done)
          state_nxt = SDE_WR_STROBE;
      SDE_WR_STROBE:
        state_nxt = SDE_DONE;
      SDE_DONE:
        state_nxt = SDE_IDLE;
      default:
        state_nxt = SDE_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= SDE_IDLE;
      cnt_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= (state_nxt != state_r) ? '0 : cnt_r + WAIT_ONE;
    end
  end

  // Software registers; orders other than clear are ignored while busy
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      addr_r <= '0;
      wdata_r <= '0;
      bytesel_r <= '0;
      rmw_r <= 1'b0;
      rd_op_r <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == REG_ADDR && state_r == SDE_IDLE)
        addr_r <= reg_wdata[MAW-1:0];
      if (reg_wr && reg_addr == REG_WDATA && state_r == SDE_IDLE)
        wdata_r <= reg_wdata[DW-1:0];
      if (reg_wr && reg_addr == REG_BYTESEL && state_r == SDE_IDLE)
        bytesel_r <= reg_wdata[1:0];
      if (start_any)
      begin
        rmw_r <= reg_wdata[CTRL_RMW_BIT];
        rd_op_r <= reg_wdata[CTRL_RD_BIT] && !reg_wdata[CTRL_RMW_BIT];
      end
    end
  end

  // Results; uncorrectable bit is sticky and its set beats a clear
  assign uncorr_set = (state_r == SDE_RD_FLAG) && wait_done && flags_uncorr;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      clean_r <= 1'b0;
      corr_r <= 1'b0;
      uncorr_r <= 1'b0;
      rdata_r <= '0;
      synd_r <= '0;
    end
    else
    begin
      if (start_any)
      begin
        clean_r <= 1'b0;
        corr_r <= 1'b0;
      end
      if (state_r == SDE_RD_FLAG && wait_done && flags_clean)
      begin
        clean_r <= 1'b1;
        if (!rmw_r)
          rdata_r <= db_s_r;
      end
      if (state_r == SDE_OUT_CORR && wait_done)
      begin
        corr_r <= 1'b1;
        rdata_r <= db_s_r;
        synd_r <= cb_s_r;
      end
      if (uncorr_set)
        uncorr_r <= 1'b1;
      else if (ctrl_wr && reg_wdata[CTRL_CLR_BIT])
        uncorr_r <= 1'b0;
    end
  end
  assign uncorr_irq = uncorr_r;

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= ZERO32;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        REG_ADDR: reg_rdata <= 32'(addr_r);
        REG_WDATA: reg_rdata <= 32'(wdata_r);
        REG_BYTESEL: reg_rdata <= 32'(bytesel_r);
        REG_STATUS: reg_rdata <= 32'({uncorr_r, corr_r, clean_r,
                                      state_r != SDE_IDLE});
        REG_RDATA: reg_rdata <= 32'(rdata_r);
        REG_SYND: reg_rdata <= 32'(synd_r);
        default: reg_rdata <= ZERO32;
      endcase
    end
    else
      reg_rdata <= ZERO32;
  end

  // Pins registered from the next state so they change cleanly
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      {mode_select_hi, mode_select_lo} <= MODE_FLAG;
      data_out_latch_ctl_n <= 1'b0;
      {high_byte_out_enable_n, low_byte_out_enable_n} <= 2'h3;
      check_port_out_enable_n <= 1'b1;
      data_word_oe_n <= 2'h3;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
    end
    else
    begin
      {mode_select_hi, mode_select_lo} <= pin_mode(state_nxt);
      // Latch follows in the capture step, then holds from the rise
      data_out_latch_ctl_n <= (state_nxt != SDE_LATCH_IN);
      mem_rd <= (state_nxt == SDE_RD_FLAG) || (state_nxt == SDE_LATCH_IN);
      mem_wr <= (state_nxt == SDE_WR_STROBE);
      unique case (state_nxt)
        SDE_OUT_CORR:
        begin
          {high_byte_out_enable_n, low_byte_out_enable_n} <= 2'h0;
          check_port_out_enable_n <= 1'b0;
          data_word_oe_n <= 2'h3;
        end
        SDE_WR_GEN, SDE_WR_STROBE:
        begin
          // Modified bytes come from the host, the rest from the latch
          {high_byte_out_enable_n, low_byte_out_enable_n} <=
            rmw_live ? bytesel_r : 2'h3;
          data_word_oe_n <= rmw_live ? ~bytesel_r : 2'h0;
          check_port_out_enable_n <= 1'b0;
        end
        default:
        begin
          {high_byte_out_enable_n, low_byte_out_enable_n} <= 2'h3;
          check_port_out_enable_n <= 1'b1;
          data_word_oe_n <= 2'h3;
        end
      endcase
    end
  end
  assign data_word_out = wdata_r;
  assign mem_addr = addr_r;

  default clocking cb_clk @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  flag_accept_a: assert property (
    (state_r == SDE_RD_FLAG && state_nxt == SDE_DONE && !uncorr_set)
      |-> flags_clean)
    else $error("read accepted without both flags high");
  corr_start_a: assert property (
    (state_r == SDE_RD_FLAG && wait_done && flags_corr)
      |=> state_r == SDE_LATCH_IN ##[1:12] state_r == SDE_HOLD)
    else $error("correctable read did not latch input");
  uncorr_irq_a: assert property (
    uncorr_set |=> uncorr_irq [*2])
    else $error("uncorrectable read did not raise interrupt");
  latch_mode_a: assert property (
    (state_r == SDE_HOLD)
      |-> {mode_select_hi, mode_select_lo} == MODE_LATCH && !mem_rd)
    else $error("latch mode not held while output latch closes");
  latch_rise_a: assert property (
    (state_r == SDE_HOLD) |-> data_out_latch_ctl_n &&
      $past(data_out_latch_ctl_n) == 1'b0)
    else $error("output latch control did not rise");
  byte_split_a: assert property (
    (state_r == SDE_WR_STROBE) |-> data_word_oe_n ==
      ~{high_byte_out_enable_n, low_byte_out_enable_n})
    else $error("host and unit drive the same byte");
  gen_mode_a: assert property (
    mem_wr |-> {mode_select_hi, mode_select_lo} == MODE_GEN &&
      !check_port_out_enable_n)
    else $error("write back without fresh check word");
  rmw_capture_a: assert property (
    (rmw_r && state_r == SDE_WR_GEN && $past(state_r) == SDE_HOLD)
      |-> $past(data_out_latch_ctl_n, 2) == 1'b0)
    else $error("byte write without captured word");
  regen_wait_a: assert property (
    (state_r == SDE_WR_STROBE) |-> $past(state_r) == SDE_WR_GEN &&
      $past(cnt_r) == WAIT_SETTLE - WAIT_ONE)
    else $error("check word not allowed to settle");

  plain_write_c: cover property (state_r == SDE_WR_STROBE && !rmw_r);
  clean_read_c: cover property (
    state_r == SDE_DONE && clean_r && rd_op_r);
  corr_read_c: cover property (state_r == SDE_OUT_CORR && wait_done);
  uncorr_read_c: cover property (uncorr_set);
  rmw_write_c: cover property (state_r == SDE_WR_STROBE && rmw_r);
endmodule

// ==== dv/sde_unit_model.sv ====
// Behavioural check/correct unit together with its memory array
module sde_unit_model (
  // Clock for the memory array
  input wire logic clk_sys,
  // Unit controls from the host
  input wire logic [1:0] mode,
  input wire logic [1:0] byte_oe_n,
  input wire logic latch_ctl_n,
  input wire logic check_oe_n,
  // Host data drive
  input wire logic [15:0] host_data,
  input wire logic [1:0] host_oe_n,
  // Memory strobes and injected faults
  input wire logic [3:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [21:0] flip_mask,
  // Resolved lines and flags
  output logic [15:0] data_lines,
  output logic [5:0] check_lines,
  output logic fault_n,
  output logic multi_n
);
  localparam logic [15:0] GM [6] = '{16'h2e4b, 16'h5715, 16'h99a6,
    16'he338, 16'hfcc0, 16'h00ff};
  logic [21:0] mem [16];
  logic [21:0] mw;
  logic [15:0] din_l, out_l, dev_d, flt;
  logic [5:0] cin_l, e;

  // Even parity per group, so an all-ones word misses all six
  function automatic logic [5:0] gen(input logic [15:0] d);
    for (int i = 0; i < 6; i++)
      gen[i] = ^(d & GM[i]);
  endfunction

  initial
    foreach (mem[i])
      mem[i] = 22'h0;

  // Released lines show a moving pattern, not the last value
  always @(posedge clk_sys)
    flt <= (flt === 16'hxxxx) ? 16'ha5c3 : ~flt;

  // Memory stores the resolved lines on a write strobe
  always @(posedge clk_sys)
    if (mem_wr)
      mem[mem_addr] <= {check_lines, data_lines};
  assign mw = mem[mem_addr] ^ flip_mask;

  // Input latches: both held in latch mode, check only in diagnostic
  always @*
    if (mode != 2'b11)
      din_l = data_lines;
  always @*
    if (!mode[0])
      cin_l = check_lines;

  // All groups checked jointly; a matching data column is inverted
  assign e = gen(din_l) ^ cin_l;
  always @*
  begin
    dev_d = din_l;
    for (int i = 0; i < 16; i++)
      if (e == gen(16'h1 << i))
        dev_d[i] = ~din_l[i];
  end

  // Flags held high while generating; 3+ flips may alias a class
  assign fault_n = (mode == 2'b00) | (e == 6'h00);
  assign multi_n = (mode == 2'b00) | (e == 6'h00) | (^e);

  // Output latch follows while its control is low
  always @*
    if (!latch_ctl_n)
      out_l = dev_d;

  // Host wins a fight here; real parts would just corrupt the bus
  always @*
    for (int b = 0; b < 2; b++)
      if (!host_oe_n[b])
        data_lines[b*8+:8] = host_data[b*8+:8];
      else if (!byte_oe_n[b])
        data_lines[b*8+:8] = out_l[b*8+:8];
      else if (mem_rd)
        data_lines[b*8+:8] = mw[b*8+:8];
      else
        data_lines[b*8+:8] = flt[b*8+:8];

  // Check port: stored word, generated word or syndrome
  always @*
    if (mem_rd)
      check_lines = mw[21:16];
    else if (check_oe_n)
      check_lines = flt[5:0];
    else if (mode == 2'b00)
      check_lines = gen(din_l);
    else
      check_lines = ~e;
endmodule

// ==== dv/testbench.sv ====
// Self-checking bench for the check-unit host controller
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import sde_pkg::*;
  localparam logic [15:0] GM [6] = '{16'h2e4b, 16'h5715, 16'h99a6,
    16'he338, 16'hfcc0, 16'h00ff};
  logic clk_sys, nrst, reg_wr, reg_rd, msh, msl, b0n, b1n, lat_n, coe_n;
  logic flt_n, mflt_n, mem_rd, mem_wr, irq;
  logic [RAW-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, r, est;
  logic [15:0] dw_in, dw_out, d, nd, md;
  logic [1:0] dw_oe_n;
  logic [5:0] cb_in, ev;
  logic [3:0] mem_addr;
  logic [21:0] flip, m;
  int n_fail = 0;
  int samples_checked = 0;
  int p, q;

  sde_host #(.MAW(4)) dut (.clk_sys(clk_sys), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mode_select_hi(msh),
    .mode_select_lo(msl), .low_byte_out_enable_n(b0n),
    .high_byte_out_enable_n(b1n), .data_out_latch_ctl_n(lat_n),
    .check_port_out_enable_n(coe_n), .fault_flag_n(flt_n),
    .multi_fault_flag_n(mflt_n), .data_word_in(dw_in),
    .data_word_out(dw_out), .data_word_oe_n(dw_oe_n),
    .check_bit_in(cb_in), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .uncorr_irq(irq));
  sde_unit_model u_unit (.clk_sys(clk_sys), .mode({msh, msl}),
    .byte_oe_n({b1n, b0n}), .latch_ctl_n(lat_n), .check_oe_n(coe_n),
    .host_data(dw_out), .host_oe_n(dw_oe_n), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .flip_mask(flip),
    .data_lines(dw_in), .check_lines(cb_in), .fault_n(flt_n),
    .multi_n(mflt_n));

  // Reference check word, written apart from the design
  function automatic logic [5:0] exp_chk(input logic [15:0] v);
    for (int i = 0; i < 6; i++)
      exp_chk[i] = ^(v & GM[i]);
  endfunction

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // A trailing idle edge keeps back-to-back strobes from colliding
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    // Read data stand in this cycle; take them at its closing edge
    @(posedge clk_sys);
    v = reg_rdata;
  endtask

  // Start an operation and poll busy under a bound
  task automatic op(input int b);
    logic [31:0] s;
    wr(REG_CTRL, 32'h1 << b);
    s = 32'h1;
    for (int i = 0; i < 60 && s[0] !== 1'b0; i++)
      rd(REG_STATUS, s);
    chk({31'h0, s[0]}, 32'h0);
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial
  begin
    #500us;
    n_fail++;
    tally_and_finish();
  end

  initial
  begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    flip = 22'h0;
    void'($urandom(94846));
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    rd(8'h1c, r);
    chk(r, 32'h0);
    rd(REG_CTRL, r);
    chk(r, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("register test done");
    // Fault kinds: none, data bit, check bit, double, all ones
    for (int i = 0; i < 15; i++)
    begin
      d = 16'($urandom);
      wr(REG_ADDR, 32'(i));
      wr(REG_WDATA, {16'h0, d});
      op(CTRL_WR_BIT);
      chk({10'h0, u_unit.mem[i]}, {10'h0, exp_chk(d), d});
      p = $urandom % 22;
      q = (p + 1 + $urandom % 21) % 22;
      case (i % 5)
        0: m = 22'h0;
        1: m = 22'h1 << ($urandom % 16);
        2: m = 22'h1 << (16 + $urandom % 6);
        3: m = (22'h1 << p) | (22'h1 << q);
        default: m = ~{exp_chk(d), d};
      endcase
      ev = exp_chk(m[15:0]) ^ m[21:16];
      est = (ev == 6'h0) ? 32'h2 : ((^ev) ? 32'h4 : 32'h8);
      flip <= m;
      op(CTRL_RD_BIT);
      flip <= 22'h0;
      rd(REG_STATUS, r);
      chk(r, est);
      if (est != 32'h8)
        md = d;
      rd(REG_RDATA, r);
      chk(r, {16'h0, md});
      rd(REG_SYND, r);
      if (est == 32'h4)
        chk(r, {26'h0, ~ev});
      chk({31'h0, irq}, {31'h0, est == 32'h8});
      wr(REG_CTRL, 32'h1 << CTRL_CLR_BIT);
      $display("read test %0d done", i);
    end
    // Byte merge over a corrected word, every non-empty byte choice (1 to 3)
    for (int bs = 1; bs < 4; bs++)
    begin
      d = 16'($urandom);
      nd = 16'($urandom);
      wr(REG_ADDR, 32'(bs));
      wr(REG_WDATA, {16'h0, d});
      op(CTRL_WR_BIT);
      wr(REG_BYTESEL, 32'(bs));
      wr(REG_WDATA, {16'h0, nd});
      flip <= 22'h1 << ($urandom % 16);
      op(CTRL_RMW_BIT);
      flip <= 22'h0;
      md[15:8] = bs[1] ? nd[15:8] : d[15:8];
      md[7:0] = bs[0] ? nd[7:0] : d[7:0];
      chk({10'h0, u_unit.mem[bs]}, {10'h0, exp_chk(md), md});
      op(CTRL_RD_BIT);
      rd(REG_RDATA, r);
      chk(r, {16'h0, md});
      $display("merge test %0d done", bs);
    end
    tally_and_finish();
  end
endmodule
